// ==== fse_pkg.sv ====
// package: register map, field positions and carriers for the flash status/error bank
package fse_pkg;

   localparam logic [3:0] FSE_ADDR_CONFIG     = 4'h4;
   localparam logic [3:0] FSE_ADDR_ERR_CONFIG = 4'h5;
   localparam logic [3:0] FSE_ADDR_STATUS     = 4'h6;
   localparam logic [3:0] FSE_ADDR_ERR_STATUS = 4'h7;

   // flash_config fields
   localparam int CFG_CMD_COMPLETE_IRQ_EN_BIT  = 7;
   localparam int CFG_IGNORE_SINGLE_FAULT_BIT = 4;
   localparam int CFG_WS_LSB    = 2;
   // error_irq_config fields
   localparam int ECFG_SFIE_BIT = 0;
   // command_status fields
   localparam int ST_CMD_COMPLETE_FLAG_BIT   = 7;
   localparam int ST_ACCESS_ERROR_FLAG_BIT = 5;
   localparam int ST_PROTECT_VIOLATION_FLAG_BIT = 4;
   localparam int ST_BUSY_BIT   = 3;
   // ecc_error_status fields
   localparam int ES_DOUBLE_FAULT_FLAG_BIT   = 1;
   localparam int ES_SINGLE_FAULT_FLAG_BIT  = 0;

   localparam logic [1:0] WS_MAX_CYCLES = 2'h0;
   localparam logic [1:0] WS_DISABLED   = 2'h3;
   localparam logic [7:0] FSE_ZERO_BYTE = 8'h00;
   localparam logic [1:0] FSE_ZERO_STAT = 2'h0;

   // maximum wait cycles needed at the core target
   localparam int WS_MAX_WAIT = 1;

   // register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } fse_bus_req_t;

   // events from the command sequencer and the ecc read path
   typedef struct packed {
      logic       cmd_done;
      logic       seq_violation;
      logic       prot_violation;
      logic       result_set;
      logic [1:0] result_bits;
      logic       single_fault;
      logic       double_fault;
   } fse_event_t;

endpackage

// ==== fse_regs.sv ====
// flash status, error status and error-interrupt configuration register bank
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// one write-one-to-clear flag; a hardware set beats a clear in the same cycle
module fse_w1c_flag #(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   input  wire logic set_i,
   input  wire logic clr_i,
   output var  logic flag_q
);

   // the set term stands outside the clear mask, so an event is never lost
   wire flag_d = set_i | (flag_q & ~clr_i);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         flag_q <= RESET_VAL;
      end else begin
         flag_q <= flag_d;
      end
   end

endmodule // fse_w1c_flag

// ==========================================================
// one software-loaded configuration field
module fse_cfg_field #(
   parameter int         WIDTH     = 1,
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   input  wire logic             load_i,
   input  wire logic [WIDTH-1:0] value_i,
   output var  logic [WIDTH-1:0] field_q
);

   if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
      $error("fse_cfg_field: WIDTH must be 1..8");
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         field_q <= RESET_VAL[WIDTH-1:0];
      end else if (load_i) begin
         field_q <= value_i;
      end
   end

endmodule // fse_cfg_field

module fse_regs #(
   parameter int WAIT_MAX = fse_pkg::WS_MAX_WAIT
) (
   input  wire logic                 ref_clk,
   input  wire logic                 sys_rst,
   input  wire fse_pkg::fse_bus_req_t bus_req,
   output var  logic [7:0]           rd_data,
   input  wire fse_pkg::fse_event_t  evt,
   input  wire logic                 reset_seq_dfault,
   output var  logic                 cmd_launch,
   output var  logic                 seq_start_allow,
   output var  logic                 cmd_irq,
   output var  logic                 error_irq,
   output var  logic                 read_wait_en,
   output var  logic [1:0]           read_wait_cycles
);

   // read_wait_cycles is two bits wide, so larger counts cannot be shown
   if (WAIT_MAX < 1 || WAIT_MAX > 3) begin : g_bad_wait_max
      $error("fse_regs: WAIT_MAX must be 1..3");
   end

   // ==========================================================
   // registers
   logic [1:0] read_wait_select_q;
   logic       ignore_single_fault_q;
   logic       cmd_complete_irq_en_q;
   logic       single_fault_irq_en_q;
   logic       cmd_complete_flag_q;
   logic       access_error_flag_q;
   logic       protect_violation_flag_q;
   logic [1:0] cmd_result_status_q;
   logic       double_fault_flag_q;
   logic       single_fault_flag_q;
   logic       rst_seen_q;

   // ==========================================================
   // write decode
   wire wr_cfg   = bus_req.wr && (bus_req.addr == fse_pkg::FSE_ADDR_CONFIG);
   wire wr_ecfg  = bus_req.wr && (bus_req.addr == fse_pkg::FSE_ADDR_ERR_CONFIG);
   wire wr_stat  = bus_req.wr && (bus_req.addr == fse_pkg::FSE_ADDR_STATUS);
   wire wr_estat = bus_req.wr && (bus_req.addr == fse_pkg::FSE_ADDR_ERR_STATUS);

   wire clr_cmd_complete_flag  = wr_stat && bus_req.wdata[fse_pkg::ST_CMD_COMPLETE_FLAG_BIT];
   wire clr_acc   = wr_stat && bus_req.wdata[fse_pkg::ST_ACCESS_ERROR_FLAG_BIT];
   wire clr_fpv   = wr_stat && bus_req.wdata[fse_pkg::ST_PROTECT_VIOLATION_FLAG_BIT];
   wire clr_double_fault_flag  = wr_estat && bus_req.wdata[fse_pkg::ES_DOUBLE_FAULT_FLAG_BIT];
   wire clr_single_fault_flag = wr_estat && bus_req.wdata[fse_pkg::ES_SINGLE_FAULT_FLAG_BIT];

   // launch needs an idle controller and no pending error flag; error flags that are
   // cleared in the same write still block this launch, software must retry
   wire launch_ok = clr_cmd_complete_flag && cmd_complete_flag_q
                    && !access_error_flag_q && !protect_violation_flag_q;

   // hardware sets take priority over same-cycle clears
   wire acc_set  = evt.seq_violation;
   wire fpv_set  = evt.prot_violation;
   wire cmd_complete_flag_set = !cmd_complete_flag_q && (evt.cmd_done || acc_set || fpv_set);
   wire sf_set   = evt.single_fault && !ignore_single_fault_q;
   wire df_set   = evt.double_fault;

   wire ws_write_ok = wr_cfg && cmd_complete_flag_q;

   // ==========================================================
   // read decode
   wire [7:0] cfg_rd  = {cmd_complete_irq_en_q, 2'h0, ignore_single_fault_q,
                         read_wait_select_q, 2'h0};
   wire [7:0] ecfg_rd = {7'h00, single_fault_irq_en_q};
   wire [7:0] stat_rd = {cmd_complete_flag_q, 1'h0, access_error_flag_q,
                         protect_violation_flag_q, !cmd_complete_flag_q,
                         1'h0, cmd_result_status_q};
   wire [7:0] estat_rd = {6'h00, double_fault_flag_q, single_fault_flag_q};
   logic [7:0] rd_sel;
   always_comb begin
      if (bus_req.addr == fse_pkg::FSE_ADDR_CONFIG) begin
         rd_sel = cfg_rd;
      end else if (bus_req.addr == fse_pkg::FSE_ADDR_ERR_CONFIG) begin
         rd_sel = ecfg_rd;
      end else if (bus_req.addr == fse_pkg::FSE_ADDR_STATUS) begin
         rd_sel = stat_rd;
      end else if (bus_req.addr == fse_pkg::FSE_ADDR_ERR_STATUS) begin
         rd_sel = estat_rd;
      end else begin
         rd_sel = fse_pkg::FSE_ZERO_BYTE;
      end
   end

   // wait decode: only 11 disables, reserved codes behave as 00
   wire       ws_en_d  = (read_wait_select_q != fse_pkg::WS_DISABLED);
   wire [1:0] ws_cyc_d = ws_en_d ? 2'(WAIT_MAX) : 2'h0;

   // ==========================================================
   // next values
   // the read path is registered, so rd_data stands only in the cycle after the strobe
   wire [7:0] rd_data_d   = bus_req.rd ? rd_sel : fse_pkg::FSE_ZERO_BYTE;
   wire       cmd_irq_d   = cmd_complete_irq_en_q & cmd_complete_flag_q;
   wire       error_irq_d = single_fault_irq_en_q & single_fault_flag_q;
   wire       allow_d     = !protect_violation_flag_q;
   wire       dfault_set  = df_set | (!rst_seen_q & reset_seq_dfault);
   wire [1:0] ws_field_d  = bus_req.wdata[fse_pkg::CFG_WS_LSB +: 2];

   // completion flag: a finishing command wins over a launch attempt
   logic cmd_complete_flag_d;
   always_comb begin
      cmd_complete_flag_d = cmd_complete_flag_q;
      if (cmd_complete_flag_set) begin
         cmd_complete_flag_d = 1'b1;
      end else if (launch_ok) begin
         cmd_complete_flag_d = 1'b0;
      end
   end

   // result bits: reset-sequence fault first, then sequencer errors, then launch clear
   logic [1:0] result_d;
   always_comb begin
      result_d = cmd_result_status_q;
      if (!rst_seen_q && reset_seq_dfault) begin
         result_d = ~fse_pkg::FSE_ZERO_STAT;
      end else if (evt.result_set) begin
         result_d = cmd_result_status_q | evt.result_bits;
      end else if (launch_ok) begin
         result_d = fse_pkg::FSE_ZERO_STAT;
      end
   end

   // ==========================================================
   // configuration registers
   fse_cfg_field #(
      .WIDTH     (2),
      .RESET_VAL ({6'h00, fse_pkg::WS_MAX_CYCLES})
   ) u_read_wait_select (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .load_i  (ws_write_ok),
      .value_i (ws_field_d),
      .field_q (read_wait_select_q)
   );

   fse_cfg_field u_ignore_single_fault (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .load_i  (wr_cfg),
      .value_i (bus_req.wdata[fse_pkg::CFG_IGNORE_SINGLE_FAULT_BIT]),
      .field_q (ignore_single_fault_q)
   );

   fse_cfg_field u_cmd_complete_irq_en (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .load_i  (wr_cfg),
      .value_i (bus_req.wdata[fse_pkg::CFG_CMD_COMPLETE_IRQ_EN_BIT]),
      .field_q (cmd_complete_irq_en_q)
   );

   fse_cfg_field u_single_fault_irq_en (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .load_i  (wr_ecfg),
      .value_i (bus_req.wdata[fse_pkg::ECFG_SFIE_BIT]),
      .field_q (single_fault_irq_en_q)
   );

   // ==========================================================
   // status flags
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cmd_complete_flag_q <= 1'b1;
      end else begin
         cmd_complete_flag_q <= cmd_complete_flag_d;
      end
   end

   // marks the first cycle after reset, when the reset-sequence fault is taken
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rst_seen_q <= 1'b0;
      end else begin
         rst_seen_q <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cmd_result_status_q <= fse_pkg::FSE_ZERO_STAT;
      end else begin
         cmd_result_status_q <= result_d;
      end
   end

   fse_w1c_flag u_access_error (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .set_i   (acc_set),
      .clr_i   (clr_acc),
      .flag_q  (access_error_flag_q)
   );

   fse_w1c_flag u_protect_violation (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .set_i   (fpv_set),
      .clr_i   (clr_fpv),
      .flag_q  (protect_violation_flag_q)
   );

   // ==========================================================
   // ecc fault flags
   // a new fault is only reliable once software has cleared the old one
   fse_w1c_flag u_double_fault (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .set_i   (dfault_set),
      .clr_i   (clr_double_fault_flag),
      .flag_q  (double_fault_flag_q)
   );

   fse_w1c_flag u_single_fault (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .set_i   (sf_set),
      .clr_i   (clr_single_fault_flag),
      .flag_q  (single_fault_flag_q)
   );

   // ==========================================================
   // outputs, all registered
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rd_data <= fse_pkg::FSE_ZERO_BYTE;
      end else begin
         rd_data <= rd_data_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cmd_launch <= 1'b0;
      end else begin
         cmd_launch <= launch_ok;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         seq_start_allow <= 1'b0;
      end else begin
         seq_start_allow <= allow_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cmd_irq <= 1'b0;
      end else begin
         cmd_irq <= cmd_irq_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         error_irq <= 1'b0;
      end else begin
         error_irq <= error_irq_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         read_wait_en <= 1'b1;
      end else begin
         read_wait_en <= ws_en_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         read_wait_cycles <= 2'(WAIT_MAX);
      end else begin
         read_wait_cycles <= ws_cyc_d;
      end
   end

endmodule // fse_regs
`default_nettype wire

// ==== fse_regs_assertions.sv ====
// checker bound to the flash status/error register bank
`timescale 1ns/1ps
`default_nettype none
module fse_regs_assertions #(
   parameter int WAIT_MAX = 1
) (
   input wire logic                  ref_clk,
   input wire logic                  sys_rst,
   input wire fse_pkg::fse_bus_req_t bus_req,
   input wire logic [7:0]            rd_data,
   input wire fse_pkg::fse_event_t   evt,
   input wire logic                  reset_seq_dfault,
   input wire logic                  cmd_launch,
   input wire logic                  seq_start_allow,
   input wire logic                  cmd_irq,
   input wire logic                  error_irq,
   input wire logic                  read_wait_en,
   input wire logic [1:0]            read_wait_cycles
);
   // ==========
   // properties
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   wire launch_wr = bus_req.wr && bus_req.addr == fse_pkg::FSE_ADDR_STATUS && bus_req.wdata[7];
   wire st_rd     = bus_req.rd && bus_req.addr == fse_pkg::FSE_ADDR_STATUS;
   wire bad_rd    = bus_req.rd && (bus_req.addr < 4'h4 || bus_req.addr > 4'h7);
   chk_rd_idle: assert property (!bus_req.rd |=> rd_data == 8'h00)
      else $error("read data not idle");
   chk_wait_decode: assert property (read_wait_cycles == (read_wait_en ? WAIT_MAX[1:0] : 2'h0))
      else $error("wait cycles disagree with enable");
   chk_launch_src: assert property (cmd_launch |-> $past(launch_wr))
      else $error("launch without a completion flag write");
   chk_launch_once: assert property (cmd_launch |=> !cmd_launch)
      else $error("launch repeated while busy");
   chk_launch_irq: assert property (cmd_launch |=> !cmd_irq)
      else $error("completion request during a command");
   chk_acc_block: assert property (evt.seq_violation ##2 launch_wr |=> !cmd_launch)
      else $error("launch while access error set");
   chk_prot_allow: assert property (evt.prot_violation |=> ##1 !seq_start_allow)
      else $error("sequence allowed after protection violation");
   chk_status_busy: assert property (st_rd |=> !rd_data[2] && rd_data[3] == !rd_data[7])
      else $error("busy or reserved status bit wrong");
   chk_unmapped_rd: assert property (bad_rd |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
endmodule // fse_regs_assertions
bind fse_regs fse_regs_assertions #(.WAIT_MAX(WAIT_MAX)) u_chk (.ref_clk(ref_clk),
   .sys_rst(sys_rst), .bus_req(bus_req), .rd_data(rd_data), .evt(evt),
   .reset_seq_dfault(reset_seq_dfault), .cmd_launch(cmd_launch), .cmd_irq(cmd_irq),
   .seq_start_allow(seq_start_allow), .error_irq(error_irq), .read_wait_en(read_wait_en),
   .read_wait_cycles(read_wait_cycles));
`default_nettype wire

// ==== fse_regs_tb.sv ====
// self-checking bench for the flash status/error register bank
`timescale 1ns/1ps
`default_nettype none
module fse_regs_tb;
   localparam logic [3:0] AC = fse_pkg::FSE_ADDR_CONFIG;
   localparam logic [3:0] AE = fse_pkg::FSE_ADDR_ERR_CONFIG;
   localparam logic [3:0] AS = fse_pkg::FSE_ADDR_STATUS;
   localparam logic [3:0] AR = fse_pkg::FSE_ADDR_ERR_STATUS;
   logic                  ref_clk, sys_rst, rst_df, done, launch, allow, cirq, eirq, ws_en;
   fse_pkg::fse_bus_req_t req;
   fse_pkg::fse_event_t   ev_q, evt_w;
   logic [7:0]            rd_data;
   logic [1:0]            ws_cyc;
   int                    miscompares = 0, checked = 0, launches = 0, cyc = 0;
   assign evt_w = ev_q | fse_pkg::fse_event_t'({done, 7'h00});
   fse_regs u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_req(req), .rd_data(rd_data),
      .evt(evt_w), .reset_seq_dfault(rst_df), .cmd_launch(launch), .seq_start_allow(allow),
      .cmd_irq(cirq), .error_irq(eirq), .read_wait_en(ws_en), .read_wait_cycles(ws_cyc));
   fse_seq_model u_seq (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_launch(launch), .cmd_done(done));
   // ==========
   // clock, launch count, timeout
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (launch === 1'b1) launches <= launches + 1;
      if (cyc == 3000) begin
         miscompares = miscompares + 1;
         conclude();
      end
   end
   // ==========
   // bus and event tasks
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      req.rd <= 1'b0;
      #1 chk(rd_data, exp);
   endtask
   // event pulse bits: done, seq, prot, result_set, result[1:0], single, double
   task automatic pulse(input logic [7:0] e);
      @(posedge ref_clk);
      ev_q <= fse_pkg::fse_event_t'(e);
      @(posedge ref_clk);
      ev_q <= '0;
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ==========
   // sequence
   initial begin
      sys_rst = 1'b1;
      rst_df = 1'b0;
      req = '0;
      ev_q = '0;
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd(AS, 8'h80);
      rd(AC, 8'h00);
      chk({ws_en, 5'h00, ws_cyc}, 8'h81);
      for (int i = 0; i < 4; i++) begin
         wr(AC, 8'h80 | 8'(i << 2));
         rd(AC, 8'h80 | 8'(i << 2));
         chk({ws_en, 5'h00, ws_cyc}, (i == 3) ? 8'h00 : 8'h81);
      end
      chk({7'h00, cirq}, 8'h01);
      wr(AC, 8'h80);
      wr(AE, 8'h01);
      rd(AE, 8'h01);
      pulse(8'h14);
      rd(AS, 8'h81);
      wr(AS, 8'h80);
      rd(AS, 8'h08);
      chk(8'(launches), 8'h01);
      wr(AC, 8'h8C);
      rd(AC, 8'h80);
      wr(AS, 8'h80);
      repeat (20) @(posedge ref_clk);
      rd(AS, 8'h80);
      chk({7'h00, cirq}, 8'h01);
      pulse(8'h40);
      wr(AS, 8'h80);
      rd(AS, 8'hA0);
      wr(AS, 8'h00);
      rd(AS, 8'hA0);
      wr(AS, 8'hA0);
      rd(AS, 8'h80);
      pulse(8'h20);
      rd(AS, 8'h90);
      chk({7'h00, allow}, 8'h00);
      wr(AS, 8'h90);
      rd(AS, 8'h80);
      chk(8'(launches), 8'h01);
      wr(AS, 8'h0F);
      rd(AS, 8'h80);
      rd(4'hA, 8'h00);
      pulse(8'h02);
      rd(AR, 8'h01);
      chk({7'h00, eirq}, 8'h01);
      wr(AR, 8'h01);
      rd(AR, 8'h00);
      pulse(8'h01);
      wr(AR, 8'h00);
      rd(AR, 8'h02);
      wr(AR, 8'h02);
      rd(AR, 8'h00);
      wr(AC, 8'h10);
      pulse(8'h02);
      rd(AR, 8'h00);
      chk({7'h00, eirq}, 8'h00);
      wr(AC, 8'h00);
      // fault and its clear land on one edge: the fault must survive
      @(posedge ref_clk);
      ev_q <= fse_pkg::fse_event_t'(8'h02);
      req <= '{addr: AR, wdata: 8'h01, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      ev_q <= '0;
      req.wr <= 1'b0;
      rd(AR, 8'h01);
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      rst_df <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_df <= 1'b0;
      rd(AS, 8'h83);
      rd(AR, 8'h02);
      conclude();
   end
endmodule // fse_regs_tb
`default_nettype wire

// ==== fse_seq_model.sv ====
// command sequencer stand-in: answers each launch with one completion pulse
`timescale 1ns/1ps
`default_nettype none
module fse_seq_model #(
   parameter int DONE_DELAY = 20
) (
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   input  wire logic cmd_launch,
   output var  logic cmd_done
);
   int cnt_q;
   // a refused launch never arrives, so no command runs and no pulse comes
   always_ff @(posedge ref_clk) begin
      cmd_done <= 1'b0;
      if (sys_rst) cnt_q <= 0;
      else if (cmd_launch) cnt_q <= DONE_DELAY;
      else if (cnt_q > 0) begin
         cnt_q <= cnt_q - 1;
         cmd_done <= (cnt_q == 1);
      end
   end
endmodule // fse_seq_model
`default_nettype wire
